// ==== sram_rtc_host_pkg.sv ====
// constants, types and pin bundle for the hidden-clock sram host controller
package sram_rtc_host_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int KEY_BITS = 64;
    localparam int XFER_BITS = 64;
    localparam int IDX_W = 6;
    localparam logic [IDX_W-1:0] IDX_LAST = 6'h3F;
    localparam logic [ADDR_W-1:0] SCRATCH_ADDR_DEF = 15'h0000;

    // bytes c5 3a a3 5c twice, bit 0 of the vector is sent first
    localparam logic [KEY_BITS-1:0] UNLOCK_KEY = 64'h5CA3_3AC5_5CA3_3AC5;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int T_SETUP_NS = 10;
    localparam int T_PULSE_NS = 100;
    localparam int T_REC_NS = 20;
    localparam int TMR_W = 8;
    localparam int SETUP_CYC_I = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_CYC_I = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int REC_CYC_I = (T_REC_NS * CLK_MHZ + 999) / 1000;
    localparam logic [TMR_W-1:0] SETUP_CYC = TMR_W'(SETUP_CYC_I);
    localparam logic [TMR_W-1:0] PULSE_CYC = TMR_W'(PULSE_CYC_I);
    localparam logic [TMR_W-1:0] REC_CYC = TMR_W'(REC_CYC_I);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_SETUP = 4'h2,
        ST_STROBE = 4'h4,
        ST_RECOV = 4'h8
    } bus_state_t;

    typedef enum logic [3:0] {
        PH_RAM = 4'h1,
        PH_OPEN = 4'h2,
        PH_KEY = 4'h4,
        PH_XFER = 4'h8
    } phase_t;

    typedef enum logic [1:0] {
        OP_RAM_RD = 2'h0,
        OP_RAM_WR = 2'h1,
        OP_CLK_RD = 2'h2,
        OP_CLK_WR = 2'h3
    } op_t;

    typedef struct packed {
        op_t op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [XFER_BITS-1:0] clk_wdata;
    } req_t;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic [XFER_BITS-1:0] clk_rdata;
        logic err;
    } rsp_t;

    typedef struct packed {
        logic chip_select_n;
        logic output_enable_n;
        logic write_enable_n;
        logic [ADDR_W-1:0] address_lines;
        logic [DATA_W-1:0] data_out;
        logic data_oe;
    } pins_t;

endpackage : sram_rtc_host_pkg

// ==== sram_rtc_host.sv ====
// host controller driving the sram pins and the hidden clock unlock and transfer
`timescale 1ns/10ps
`default_nettype none
module sram_rtc_host
    import sram_rtc_host_pkg::*;
#(
    parameter int ADDR_BITS = ADDR_W,
    parameter int DATA_BITS = DATA_W,
    parameter logic [ADDR_W-1:0] SCRATCH_ADDR = SCRATCH_ADDR_DEF
) (
    input wire logic clock_i, // 125 mhz clock
    input wire logic reset_i, // async reset, active high
    input wire logic req_valid_i, // request offered
    output logic req_ready_o, // request taken when valid too
    input wire req_t req_i, // request fields
    output logic done_o, // one-cycle completion pulse
    output rsp_t rsp_o, // response fields, held until the next request is taken
    input wire logic power_fail_i, // supply below power_fail_threshold
    output pins_t pins_o, // strobes, address_lines, data_lines out and enable
    input wire logic [DATA_W-1:0] data_lines_i // data_lines as seen on the bus
);

    if (ADDR_BITS != ADDR_W || DATA_BITS != DATA_W) begin : g_bad_width
        $error("sram_rtc_host: bus widths are fixed by the device");
    end
    if (SETUP_CYC_I < 2 || PULSE_CYC_I < 1 || REC_CYC_I < 1 || PULSE_CYC_I > 255) begin : g_bad_time
        $error("sram_rtc_host: timing counts out of range");
    end

    // ------------------------------------------------------------
    // request capture and sequencing state
    // ------------------------------------------------------------
    bus_state_t st_q;
    phase_t ph_q;
    op_t op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [XFER_BITS-1:0] clk_wdata_q;
    logic [IDX_W-1:0] idx_q;
    logic [TMR_W-1:0] tmr_q;

    logic take;
    logic go_strobe;
    logic go_recov;
    logic cyc_end;
    logic seq_last;
    logic abort;
    logic wr_cyc;
    logic out_bit;

    assign req_ready_o = (st_q == ST_IDLE) && !power_fail_i;
    assign take = req_valid_i && req_ready_o;
    assign go_strobe = (st_q == ST_SETUP) && (tmr_q == '0);
    assign go_recov = (st_q == ST_STROBE) && (tmr_q == '0);
    assign cyc_end = (st_q == ST_RECOV) && (tmr_q == '0);
    assign abort = cyc_end && power_fail_i;
    assign seq_last = (ph_q == PH_RAM) || ((ph_q == PH_XFER) && (idx_q == IDX_LAST));

    // key writes always write; the opening cycle always reads
    always_comb begin
        wr_cyc = 1'b0;
        unique case (ph_q)
            PH_RAM: wr_cyc = (op_q == OP_RAM_WR);
            PH_OPEN: wr_cyc = 1'b0;
            PH_KEY: wr_cyc = 1'b1;
            PH_XFER: wr_cyc = (op_q == OP_CLK_WR);
        endcase
    end

    assign out_bit = (ph_q == PH_KEY) ? UNLOCK_KEY[idx_q] : clk_wdata_q[idx_q];

    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            op_q <= OP_RAM_RD;
            addr_q <= '0;
            wdata_q <= '0;
            clk_wdata_q <= '0;
        end else if (take) begin
            op_q <= req_i.op;
            addr_q <= req_i.addr;
            wdata_q <= req_i.wdata;
            clk_wdata_q <= req_i.clk_wdata;
        end
    end

    // ------------------------------------------------------------
    // bus cycle engine
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            st_q <= ST_IDLE;
            tmr_q <= '0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    if (take) begin
                        st_q <= ST_SETUP;
                        tmr_q <= SETUP_CYC - 8'h01;
                    end
                end
                ST_SETUP: begin
                    if (go_strobe) begin
                        st_q <= ST_STROBE;
                        tmr_q <= PULSE_CYC - 8'h01;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                ST_STROBE: begin
                    if (go_recov) begin
                        st_q <= ST_RECOV;
                        tmr_q <= REC_CYC - 8'h01;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
                ST_RECOV: begin
                    if (cyc_end && (seq_last || abort)) begin
                        st_q <= ST_IDLE;
                    end else if (cyc_end) begin
                        st_q <= ST_SETUP;
                        tmr_q <= SETUP_CYC - 8'h01;
                    end else begin
                        tmr_q <= tmr_q - 8'h01;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // phase and bit pointer
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            ph_q <= PH_RAM;
            idx_q <= '0;
        end else if (take) begin
            ph_q <= (req_i.op[1]) ? PH_OPEN : PH_RAM;
            idx_q <= '0;
        end else if (cyc_end && !abort) begin
            unique case (ph_q)
                PH_RAM: ph_q <= PH_RAM;
                PH_OPEN: ph_q <= PH_KEY;
                PH_KEY: begin
                    if (idx_q == IDX_LAST) begin
                        ph_q <= PH_XFER;
                    end
                    idx_q <= idx_q + 6'h01;
                end
                PH_XFER: idx_q <= idx_q + 6'h01;
            endcase
        end
    end

    // ------------------------------------------------------------
    // pins: registered, address held across each cycle
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            pins_o <= '{chip_select_n: 1'b1, output_enable_n: 1'b1, write_enable_n: 1'b1,
                        address_lines: '0, data_out: '0, data_oe: 1'b0};
        end else if ((st_q == ST_SETUP) && (tmr_q == SETUP_CYC - 8'h01)) begin
            pins_o.address_lines <= (ph_q == PH_RAM) ? addr_q : SCRATCH_ADDR;
            pins_o.data_oe <= wr_cyc;
            pins_o.data_out <= (ph_q == PH_RAM) ? wdata_q : {7'h00, out_bit};
        end else if (go_strobe) begin
            pins_o.chip_select_n <= 1'b0;
            pins_o.write_enable_n <= !wr_cyc;
            pins_o.output_enable_n <= wr_cyc;
        end else if (go_recov) begin
            pins_o.chip_select_n <= 1'b1;
            pins_o.write_enable_n <= 1'b1;
            pins_o.output_enable_n <= 1'b1;
        end else if (cyc_end) begin
            pins_o.data_oe <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read capture and completion
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            rsp_o <= '0;
            done_o <= 1'b0;
        end else begin
            done_o <= cyc_end && (seq_last || abort);
            if (take) begin
                rsp_o.err <= 1'b0;
            end
            if (abort) begin
                rsp_o.err <= 1'b1;
            end
            if (go_recov && !wr_cyc && (ph_q == PH_RAM)) begin
                rsp_o.rdata <= data_lines_i;
            end
            if (go_recov && !wr_cyc && (ph_q == PH_XFER)) begin
                rsp_o.clk_rdata[idx_q] <= data_lines_i[0];
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    logic [TMR_W-1:0] we_high_q;
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            we_high_q <= 8'hFF;
        end else if (!pins_o.write_enable_n) begin
            we_high_q <= '0;
        end else if (we_high_q != 8'hFF) begin
            we_high_q <= we_high_q + 8'h01;
        end
    end

    property p_oe_high_in_write;
        !pins_o.write_enable_n |-> pins_o.output_enable_n && pins_o.data_oe;
    endproperty
    a_oe_high_in_write: assert property (p_oe_high_in_write) else $error("oe low in write");
    property p_no_drive_on_read;
        !pins_o.output_enable_n |-> !pins_o.data_oe && pins_o.write_enable_n;
    endproperty
    a_no_drive_on_read: assert property (p_no_drive_on_read) else $error("bus contention");
    property p_addr_stable;
        !pins_o.chip_select_n && $past(!pins_o.chip_select_n) |-> $stable(pins_o.address_lines);
    endproperty
    a_addr_stable: assert property (p_addr_stable) else $error("address moved in cycle");
    property p_recovery;
        $fell(pins_o.chip_select_n) |-> we_high_q >= REC_CYC + SETUP_CYC;
    endproperty
    a_recovery: assert property (p_recovery) else $error("recovery too short");
    property p_key_bit;
        !pins_o.write_enable_n && (ph_q == PH_KEY) |-> pins_o.data_out[0] == UNLOCK_KEY[idx_q];
    endproperty
    a_key_bit: assert property (p_key_bit) else $error("wrong unlock bit");
    property p_no_read_in_key;
        (ph_q == PH_KEY) |-> pins_o.output_enable_n;
    endproperty
    a_no_read_in_key: assert property (p_no_read_in_key) else $error("read during unlock");
    property p_open_is_read;
        (ph_q == PH_OPEN) && !pins_o.chip_select_n |-> !pins_o.output_enable_n;
    endproperty
    a_open_is_read: assert property (p_open_is_read) else $error("opening cycle not a read");
    property p_pf_blocks;
        power_fail_i |-> !req_ready_o ##1 (st_q == ST_IDLE) || $past(st_q != ST_IDLE);
    endproperty
    a_pf_blocks: assert property (p_pf_blocks) else $error("accepted under power fail");

    property p_xfer_after_key;
        $rose(ph_q == PH_XFER) |-> $past(idx_q) == IDX_LAST && idx_q == '0;
    endproperty
    a_xfer_after_key: assert property (p_xfer_after_key) else $error("transfer before 64 keys");

    property p_scratch_addr;
        (ph_q != PH_RAM) && !pins_o.chip_select_n |-> pins_o.address_lines == SCRATCH_ADDR;
    endproperty
    a_scratch_addr: assert property (p_scratch_addr) else $error("clock cycle off scratch");

    c_ram_write: cover property (take && req_i.op == OP_RAM_WR ##[1:100] done_o);
    c_clk_read: cover property ($rose(ph_q == PH_XFER) && op_q == OP_CLK_RD);
    c_clk_write_done: cover property (done_o && op_q == OP_CLK_WR && !rsp_o.err);
    c_abort: cover property (abort);

endmodule : sram_rtc_host
`default_nettype wire

// ==== sram_rtc_dev_model.sv ====
// behavioural model of the battery sram with its hidden serial clock
`timescale 1ns/10ps
`default_nettype none
module sram_rtc_dev_model import sram_rtc_host_pkg::*; #(
    parameter int DAY_REG = 4 // slot of the day register, plain default
) (
    input wire pins_t pins_i, // bus pins from the host
    input wire logic [DATA_W-1:0] data_i, // resolved data_lines level
    input wire logic power_fail_i, // supply below power_fail_threshold
    input wire logic external_abort_n, // low aborts a clock transfer
    output logic drive_o, // device drives data_lines
    output logic [DATA_W-1:0] data_o // device value, flipped stale value when released
);
    logic [DATA_W-1:0] ram [0:(1<<ADDR_W)-1];
    logic [XFER_BITS-1:0] clk_regs = 64'h0;
    logic [XFER_BITS-1:0] stage = 64'h0;
    logic [DATA_W-1:0] last_q = 8'h00;
    logic [DATA_W-1:0] rd_val;
    int ptr = 0;
    int cnt = 0;
    bit key_ok = 1'b0;
    bit xfer = 1'b0;
    bit wr_act = 1'b0;
    bit rd_act = 1'b0;
    wire logic wr_n = pins_i.chip_select_n | pins_i.write_enable_n;
    wire logic rd_n = pins_i.chip_select_n | pins_i.output_enable_n | ~pins_i.write_enable_n;

    assign rd_val = xfer ? {7'h55, clk_regs[cnt]} : ram[pins_i.address_lines];
    assign drive_o = !rd_n && !power_fail_i;
    assign data_o = drive_o ? rd_val : ~last_q;
    always @(rd_val or drive_o) if (drive_o) last_q = rd_val;

    always @(negedge wr_n) wr_act = 1'b1;
    always @(negedge rd_n) rd_act = 1'b1;

    // a write lands when the first strobe rises
    always @(posedge wr_n) begin
        if (wr_act && !power_fail_i) begin
            if (xfer) begin
                stage[cnt] = data_i[0];
                cnt++;
                xfer = (cnt < XFER_BITS);
                // bcd digits and mode bits are kept exactly as written
                if (!xfer) clk_regs = stage;
            end else begin
                ram[pins_i.address_lines] = data_i;
                if (key_ok && data_i[0] === UNLOCK_KEY[ptr]) ptr++;
                else key_ok = 1'b0;
                if (ptr == KEY_BITS) begin
                    xfer = 1'b1;
                    cnt = 0;
                    stage = clk_regs;
                    ptr = 0;
                    key_ok = 1'b0;
                end
            end
        end
        wr_act = 1'b0;
    end

    // with the day register's abort enable bit clear, the pin drops a transfer unapplied
    always @(negedge external_abort_n) begin
        if (xfer && !clk_regs[DAY_REG*8+4]) xfer = 1'b0;
    end

    always @(posedge rd_n) begin
        if (rd_act && !power_fail_i) begin
            if (xfer) begin
                cnt++;
                xfer = (cnt < XFER_BITS);
            end else begin
                ptr = 0;
                key_ok = 1'b1;
            end
        end
        rd_act = 1'b0;
    end
endmodule : sram_rtc_dev_model
`default_nettype wire

// ==== sram_rtc_host_bench.sv ====
// self-checking bench for the hidden-clock sram host controller
`timescale 1ns/10ps
`default_nettype none
module sram_rtc_host_bench import sram_rtc_host_pkg::*; ();
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic req_ready_o;
    req_t req_i = '0;
    logic done_o;
    rsp_t rsp_o;
    logic power_fail_i = 1'b0;
    logic ext_abort_n = 1'b1;
    localparam int DAY_REG = 4; // day register slot, same plain default as the model
    pins_t pins_o;
    logic dev_drive;
    logic [DATA_W-1:0] dev_data;
    logic [DATA_W-1:0] bus;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int i;
    logic [31:0] seed = 32'd41;
    logic [1:0] sel_q[$];
    logic [63:0] exp_q[$];
    logic [1:0] sel;
    logic [63:0] expv;
    logic [63:0] cw;
    logic [ADDR_W-1:0] a [0:5];
    logic [7:0] mirror [logic [ADDR_W-1:0]];

    assign bus = pins_o.data_oe ? pins_o.data_out : dev_data;

    sram_rtc_host dut (.clock_i(clock_i), .reset_i(reset_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_i(req_i), .done_o(done_o), .rsp_o(rsp_o),
        .power_fail_i(power_fail_i), .pins_o(pins_o), .data_lines_i(bus));
    sram_rtc_dev_model #(.DAY_REG(DAY_REG)) dev (.pins_i(pins_o), .data_i(bus),
        .power_fail_i(power_fail_i), .external_abort_n(ext_abort_n), .drive_o(dev_drive),
        .data_o(dev_data));

    initial forever #4 clock_i = ~clock_i;

    // --------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out

    // sel: 0 ram data, 1 clock data, 2 error flag, 3 clean completion
    task automatic do_op(input op_t op, input logic [ADDR_W-1:0] ad, input logic [63:0] d,
                         input logic [1:0] s, input logic [63:0] e);
        while (req_ready_o !== 1'b1) @(negedge clock_i);
        req_i.op = op;
        req_i.addr = ad;
        req_i.wdata = d[7:0];
        req_i.clk_wdata = d;
        req_valid_i = 1'b1;
        sel_q.push_back(s);
        exp_q.push_back(e);
        @(negedge clock_i);
        req_valid_i = 1'b0;
        while (done_o !== 1'b1) @(negedge clock_i);
        @(negedge clock_i);
    endtask : do_op

    // --------------------------------------------------------
    // result watcher and hang guard
    // --------------------------------------------------------
    always @(negedge clock_i) begin
        if (dev_drive === 1'b1 && pins_o.data_oe === 1'b1) check(64'h1, 64'h0);
        if (done_o === 1'b1) begin
            if (sel_q.size() == 0) begin
                check(64'h1, 64'h0);
            end else begin
                sel = sel_q.pop_front();
                expv = exp_q.pop_front();
                case (sel)
                    2'h0: check(64'(rsp_o.rdata), expv);
                    2'h1: check(rsp_o.clk_rdata, expv);
                    2'h2: check(64'(rsp_o.err), expv);
                    default: check(64'(rsp_o.err), 64'h0);
                endcase
            end
        end
    end

    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            close_out();
        end
    end

    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        repeat (20) @(negedge clock_i);
        reset_i = 1'b0;
        @(negedge clock_i);
        check(64'(pins_o.chip_select_n & pins_o.write_enable_n), 64'h1);
        check(64'(pins_o.data_oe), 64'h0);
        for (i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            a[i] = {seed[14:1], 1'b1};
            mirror[a[i]] = seed[23:16];
            do_op(OP_RAM_WR, a[i], 64'(seed[23:16]), 2'h3, 64'h0);
        end
        for (i = 5; i >= 0; i--) do_op(OP_RAM_RD, a[i], 64'h0, 2'h0, 64'(mirror[a[i]]));
        for (i = 0; i < 16; i++) begin
            seed = lfsr(seed);
            cw[4*i +: 4] = 4'(seed[3:0] % 4'hA);
        end
        cw[DAY_REG*8+4] = 1'b0;
        do_op(OP_CLK_WR, SCRATCH_ADDR_DEF, cw, 2'h3, 64'h0);
        check(dev.clk_regs, cw);
        // abort pin pulled low inside the transfer leaves the registers as they were
        fork
            do_op(OP_CLK_WR, SCRATCH_ADDR_DEF, {cw[31:0], cw[63:32]}, 2'h3, 64'h0);
            begin
                repeat (1500) @(negedge clock_i);
                ext_abort_n = 1'b0;
                @(negedge clock_i);
                ext_abort_n = 1'b1;
            end
        join
        check(dev.clk_regs, cw);
        do_op(OP_CLK_RD, SCRATCH_ADDR_DEF, 64'h0, 2'h1, cw);
        // ordinary memory is back once the transfer is over
        do_op(OP_RAM_RD, a[0], 64'h0, 2'h0, 64'(mirror[a[0]]));
        power_fail_i = 1'b1;
        @(negedge clock_i);
        check(64'(req_ready_o), 64'h0);
        power_fail_i = 1'b0;
        @(negedge clock_i);
        // supply drops during a write: aborted and not stored
        fork
            do_op(OP_RAM_WR, a[1], 64'(~mirror[a[1]]), 2'h2, 64'h1);
            begin
                repeat (3) @(negedge clock_i);
                power_fail_i = 1'b1;
                repeat (30) @(negedge clock_i);
                power_fail_i = 1'b0;
            end
        join
        do_op(OP_RAM_RD, a[1], 64'h0, 2'h0, 64'(mirror[a[1]]));
        close_out();
    end
endmodule : sram_rtc_host_bench
`default_nettype wire
